// file: eeprom_pkg.sv
// Shared constants, types and command decoding for the serial EEPROM core
package eeprom_pkg;

	// Opcodes with the don't-care bit 3 cleared
	localparam logic [7:0] OPCODE_CARE_MASK = 8'hF7;
	localparam logic [7:0] OP_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
	localparam logic [7:0] OP_STATUS_STORE = 8'h01;
	localparam logic [7:0] OP_ARRAY_FETCH = 8'h03;
	localparam logic [7:0] OP_ARRAY_STORE = 8'h02;

	// Status register layout
	localparam int BUSY_BIT = 0;
	localparam int LATCH_BIT = 1;
	localparam int GUARD_LO_BIT = 2;
	localparam int GUARD_HI_BIT = 3;
	localparam int PIN_GUARD_BIT = 7;
	localparam logic [7:0] STATUS_BUSY_IMAGE = 8'hFF;
	localparam logic [1:0] BLOCK_GUARD_RESET = 2'h0;
	localparam logic PIN_GUARD_RESET = 1'b0;

	// Address and page geometry
	localparam int ADDR_PHASE_BITS = 16;
	localparam int SMALL_ADDR_W = 14;
	localparam int LARGE_ADDR_W = 15;
	localparam int PAGE_BITS = 6;
	localparam int PAGE_BYTES = 64;
	localparam int FIFO_DEPTH = 8;

	// Self-timed write cycle, longest time rounded down to clocks
	localparam int CLOCK_PERIOD_NS = 4;
	localparam int WRITE_TIME_NS = 5_000_000;
	localparam int WRITE_CYCLES = WRITE_TIME_NS / CLOCK_PERIOD_NS;

	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_LATCH_SET = 3'h1,
		CMD_LATCH_CLEAR = 3'h2,
		CMD_STATUS_FETCH = 3'h3,
		CMD_STATUS_STORE = 3'h4,
		CMD_ARRAY_FETCH = 3'h5,
		CMD_ARRAY_STORE = 3'h6
	} cmd_t;

	// Gray codes along idle, opcode, address, payload
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_OPCODE = 3'h1,
		PH_ADDRESS = 3'h3,
		PH_PAYLOAD = 3'h2,
		PH_STATUS = 3'h6,
		PH_DISCARD = 3'h4
	} phase_t;

	// Opcode to command; only the status fetch survives a busy device
	function automatic cmd_t decode_cmd(input logic [7:0] op,
		input logic busy);
		logic [7:0] k;
		cmd_t c;
		k = op & OPCODE_CARE_MASK;
		c = CMD_NONE;
		if (k == OP_LATCH_SET) c = CMD_LATCH_SET;
		else if (k == OP_LATCH_CLEAR) c = CMD_LATCH_CLEAR;
		else if (k == OP_STATUS_FETCH) c = CMD_STATUS_FETCH;
		else if (k == OP_STATUS_STORE) c = CMD_STATUS_STORE;
		else if (k == OP_ARRAY_FETCH) c = CMD_ARRAY_FETCH;
		else if (k == OP_ARRAY_STORE) c = CMD_ARRAY_STORE;
		if (busy && c != CMD_STATUS_FETCH) c = CMD_NONE;
		return c;
	endfunction : decode_cmd

endpackage : eeprom_pkg

// file: spi_eeprom_command_protect.sv
// Serial EEPROM command, protection and array logic with read prefetch FIFO
// Notes on behaviour
// (RULE1) Frame opens on select fall, MSB first
// (RULE2) Latch set and clear opcodes, bit 3 ignored
// (RULE3) Write latch cleared at power-up
// (RULE4) Latch clear blocks programming regardless of pin
// (RULE5) Status fetch shifts eight status bits out
// (RULE6) Status bit 0 shows write cycle busy
// (RULE7) Status bit 1 mirrors the write latch
// (RULE8) Bits 4-6 zero; all ones while busy
// (RULE9) Status store updates guard pair, pin guard
// (RULE10) Guard bits need latch, timed busy cycle
// (RULE11) Guard pair selects none, quarter, half, all
// (RULE12) Pin low plus pin guard refuses status stores
// (RULE13) Guarded range never programmed; others need latch
// (RULE14) Pin guard cannot clear while pin low
// (RULE15) Read streams bytes, address wraps to zero
// (RULE16) Sixteen address bits, upper ones ignored
// (RULE17) Master enables latch; device skips guarded addresses
// (RULE18) Busy device serves only status fetch
// (RULE19) Programming starts at select rise after byte
// (RULE20) Page of 64 bytes, low six bits wrap
// (RULE21) Write latch clears when write cycle ends
// (RULE22) Store without latch ignored until next frame
// (RULE23) Unknown opcode: nothing in, output floats
// (RULE24) Hold pauses shifting and floats output
// (RULE25) Pin fall during status store abandons it; code does so only while pin guard set
// (RULE26) Clock mode 0: sample rise, drive fall
// (RULE27) Write cycle length is a parameter
`timescale 1ns/10ps

// Byte FIFO between array fetch and the serial shifter
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PTR_W = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_depth_check
		$error("byte_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0] fill;
	logic push;
	logic pop;

	assign in_ready_o = (fill != (PTR_W+1)'(DEPTH));
	assign out_valid_o = (fill != '0);
	assign out_data_o = store[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Pointers and fill level
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else if (flush_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			if (push) wr_ptr <= wr_ptr + 1'b1;
			if (pop) rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop) fill <= fill + 1'b1;
			else if (pop && !push) fill <= fill - 1'b1;
		end
	end

	// Storage
	always_ff @(posedge clock_i) begin
		if (push) store[wr_ptr] <= in_data_i;
	end
endmodule : byte_fifo

// Device top: pins sampled by the core clock
module spi_eeprom_command_protect #(
	parameter int ADDR_W = eeprom_pkg::LARGE_ADDR_W,
	parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
	parameter int PREFETCH_DEPTH = eeprom_pkg::FIFO_DEPTH
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic hold_n_i,
	input wire logic wp_n_i,
	output logic so_o,
	output logic so_oe_o
);
	import eeprom_pkg::*;

	if (ADDR_W != SMALL_ADDR_W && ADDR_W != LARGE_ADDR_W) begin : g_addr_check
		$error("ADDR_W must select the small or the large array");
	end
	if (WRITE_CYCLES < PAGE_BYTES) begin : g_cycle_check
		$error("WRITE_CYCLES must cover the page copy");
	end

	localparam int BASE_W = ADDR_W - PAGE_BITS;
	localparam logic [31:0] LAST_TICK = 32'(WRITE_CYCLES - 1);

	// Pin synchronisers: cs, sck, si, hold, wp
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;
	logic sck_prev;
	logic cs_prev;
	logic wp_prev;
	logic cs_s;
	logic sck_s;
	logic si_s;
	logic hold_s;
	logic wp_s;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_meta <= 5'h19; // Idle levels, sck low
			pin_sync <= 5'h19;
			sck_prev <= 1'b0;
			cs_prev <= 1'b1;
			wp_prev <= 1'b1;
		end else begin
			pin_meta <= {wp_n_i, hold_n_i, si_i, sck_i, cs_n_i};
			pin_sync <= pin_meta;
			sck_prev <= pin_sync[1];
			cs_prev <= pin_sync[0];
			wp_prev <= pin_sync[4];
		end
	end

	assign cs_s = pin_sync[0];
	assign sck_s = pin_sync[1];
	assign si_s = pin_sync[2];
	assign hold_s = pin_sync[3];
	assign wp_s = pin_sync[4];

	// Edge events seen by the core clock
	logic cs_fall;
	logic cs_rise;
	logic held;
	logic rx_fire;
	logic tx_fire;

	assign cs_fall = cs_prev && !cs_s; // RULE1
	assign cs_rise = !cs_prev && cs_s;

	// Hold only changes while sck is low
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) held <= 1'b0;
		else if (cs_s) held <= 1'b0;
		else if (!sck_s) held <= !hold_s; // RULE24
	end

	assign rx_fire = !cs_s && !held && sck_s && !sck_prev; // RULE26
	assign tx_fire = !cs_s && !held && !sck_s && sck_prev; // RULE26

	// Frame decoder state
	phase_t phase;
	cmd_t cmd;
	logic [2:0] bit_cnt;
	logic addr_second;
	logic [7:0] rx_byte;
	logic [7:0] rx_next;
	logic byte_done;
	logic [ADDR_PHASE_BITS-1:0] addr_sh;
	logic [ADDR_PHASE_BITS-1:0] addr_next;
	logic addr_done;
	cmd_t op_cmd;
	logic busy;

	assign rx_next = {rx_byte[6:0], si_s}; // RULE1
	assign byte_done = rx_fire && bit_cnt == 3'h7;
	assign addr_next = {addr_sh[ADDR_PHASE_BITS-2:0], si_s};
	assign addr_done = byte_done && phase == PH_ADDRESS && addr_second;
	assign op_cmd = decode_cmd(rx_next, busy); // RULE2 RULE18

	// Bit and byte framing
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bit_cnt <= 3'h0;
			rx_byte <= 8'h00;
			addr_sh <= '0;
			addr_second <= 1'b0;
		end else if (cs_fall) begin
			bit_cnt <= 3'h0;
			addr_second <= 1'b0;
		end else if (rx_fire && phase != PH_DISCARD) begin // RULE23
			bit_cnt <= bit_cnt + 3'h1;
			rx_byte <= rx_next;
			if (phase == PH_ADDRESS) addr_sh <= addr_next; // RULE16
			if (byte_done && phase == PH_ADDRESS) addr_second <= 1'b1;
		end
	end

	// Phase and command sequencing
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase <= PH_IDLE;
			cmd <= CMD_NONE;
		end else if (cs_fall) begin
			phase <= PH_OPCODE;
			cmd <= CMD_NONE;
		end else if (cs_s) begin
			phase <= PH_IDLE;
		end else if (byte_done && phase == PH_OPCODE) begin
			cmd <= op_cmd;
			case (op_cmd)
				CMD_STATUS_FETCH: phase <= PH_STATUS; // RULE5
				CMD_STATUS_STORE: phase <= PH_PAYLOAD;
				CMD_ARRAY_FETCH: phase <= PH_ADDRESS;
				CMD_ARRAY_STORE: phase <= PH_ADDRESS;
				default: phase <= PH_DISCARD; // RULE23
			endcase
		end else if (addr_done) begin
			phase <= PH_PAYLOAD;
		end
	end

	// Write latch, protection bits and hardware guard
	logic wel;
	logic [1:0] block_guard;
	logic pin_guard;
	logic hw_guard;
	logic wp_dropped;
	logic busy_end;
	logic stat_go;
	logic store_go;

	assign hw_guard = !wp_s && pin_guard; // RULE12

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) wel <= 1'b0; // RULE3
		else if (busy_end) wel <= 1'b0; // RULE21
		else if (byte_done && phase == PH_OPCODE) begin
			if (op_cmd == CMD_LATCH_SET) wel <= 1'b1; // RULE2
			else if (op_cmd == CMD_LATCH_CLEAR) wel <= 1'b0; // RULE4
		end
	end

	// Pin fall inside a frame voids a pending status store while pin guard is set
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) wp_dropped <= 1'b0;
		else if (!cs_s && wp_prev && !wp_s) wp_dropped <= 1'b1; // RULE25
		else if (cs_fall) wp_dropped <= 1'b0;
	end

	// Status store payload capture
	logic [7:0] st_byte;
	logic st_have;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_byte <= 8'h00;
			st_have <= 1'b0;
		end else if (cs_fall) begin
			st_have <= 1'b0;
		end else if (byte_done && phase == PH_PAYLOAD &&
			cmd == CMD_STATUS_STORE) begin
			st_byte <= rx_next;
			st_have <= 1'b1;
		end
	end

	assign stat_go = cs_rise && cmd == CMD_STATUS_STORE && st_have &&
		bit_cnt == 3'h0 && wel && !hw_guard && // RULE10 RULE12 RULE14
		!(wp_dropped && pin_guard); // RULE25

	// Nonvolatile protection bits
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			block_guard <= BLOCK_GUARD_RESET;
			pin_guard <= PIN_GUARD_RESET;
		end else if (stat_go) begin
			block_guard <= {st_byte[GUARD_HI_BIT], st_byte[GUARD_LO_BIT]}; // RULE9
			pin_guard <= st_byte[PIN_GUARD_BIT]; // RULE9
		end
	end

	// Guarded range test on the top address bits
	function automatic logic in_guarded(input logic [ADDR_W-1:0] a,
		input logic [1:0] g);
		logic r;
		r = 1'b0;
		case (g) // RULE11
			2'h1: r = (a[ADDR_W-1 -: 2] == 2'h3);
			2'h2: r = a[ADDR_W-1];
			2'h3: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : in_guarded

	// Page buffer for array stores
	logic [7:0] pg_data [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pg_mask;
	logic [PAGE_BITS-1:0] pg_ptr;
	logic [BASE_W-1:0] pg_base;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pg_mask <= '0;
			pg_ptr <= '0;
			pg_base <= '0;
		end else if (cs_fall && !busy) begin
			pg_mask <= '0;
		end else if (addr_done && cmd == CMD_ARRAY_STORE) begin
			pg_ptr <= addr_next[PAGE_BITS-1:0];
			pg_base <= addr_next[ADDR_W-1:PAGE_BITS]; // RULE16
		end else if (byte_done && phase == PH_PAYLOAD &&
			cmd == CMD_ARRAY_STORE) begin
			pg_mask[pg_ptr] <= 1'b1;
			pg_ptr <= pg_ptr + 1'b1; // RULE20
		end
	end

	always_ff @(posedge clock_i) begin
		if (byte_done && phase == PH_PAYLOAD && cmd == CMD_ARRAY_STORE)
			pg_data[pg_ptr] <= rx_next;
	end

	assign store_go = cs_rise && cmd == CMD_ARRAY_STORE && // RULE19
		phase == PH_PAYLOAD && bit_cnt == 3'h0 && pg_mask != '0 &&
		wel && // RULE13 RULE22
		!in_guarded({pg_base, {PAGE_BITS{1'b0}}}, block_guard); // RULE13 RULE17

	// Self-timed write cycle
	logic [31:0] tick;
	logic prog_array;

	assign busy_end = busy && tick == LAST_TICK;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy <= 1'b0;
			tick <= 32'h0000_0000;
			prog_array <= 1'b0;
		end else if (busy) begin
			tick <= tick + 32'h0000_0001; // RULE27
			if (busy_end) busy <= 1'b0;
		end else if (store_go || stat_go) begin
			busy <= 1'b1; // RULE10
			tick <= 32'h0000_0000;
			prog_array <= store_go;
		end
	end

	// Memory array, page copied during the first busy cycles
	logic [7:0] mem [1 << ADDR_W];
	logic [PAGE_BITS-1:0] copy_idx;

	assign copy_idx = tick[PAGE_BITS-1:0];

	always_ff @(posedge clock_i) begin
		if (busy && prog_array && tick < 32'(PAGE_BYTES) && pg_mask[copy_idx])
			mem[{pg_base, copy_idx}] <= pg_data[copy_idx]; // RULE20
	end

	// Read prefetch into the FIFO
	logic fetch_on;
	logic [ADDR_W-1:0] rd_addr;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic tx_load;
	logic fifo_pop;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fetch_on <= 1'b0;
			rd_addr <= '0;
		end else if (cs_s) begin
			fetch_on <= 1'b0;
		end else if (addr_done && cmd == CMD_ARRAY_FETCH) begin
			fetch_on <= 1'b1;
			rd_addr <= addr_next[ADDR_W-1:0]; // RULE16
		end else if (fetch_on && fifo_in_ready) begin
			rd_addr <= rd_addr + 1'b1; // RULE15
		end
	end

	byte_fifo #(
		.WIDTH(8),
		.DEPTH(PREFETCH_DEPTH)
	) prefetch (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.flush_i(cs_s),
		.in_valid_i(fetch_on),
		.in_ready_o(fifo_in_ready),
		.in_data_i(mem[rd_addr]),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_out_data)
	);

	// Status image seen by the master
	function automatic logic [7:0] status_image(input logic b,
		input logic w, input logic [1:0] g, input logic p);
		logic [7:0] s;
		s = 8'h00; // RULE8
		s[BUSY_BIT] = b; // RULE6
		s[LATCH_BIT] = w; // RULE7
		s[GUARD_LO_BIT] = g[0];
		s[GUARD_HI_BIT] = g[1];
		s[PIN_GUARD_BIT] = p;
		if (b) s = STATUS_BUSY_IMAGE; // RULE8
		return s;
	endfunction : status_image

	// Serial output shifter, driven after each falling sck
	logic tx_phase;
	logic [2:0] tx_cnt;
	logic [7:0] tx_sh;
	logic [7:0] tx_byte;
	logic driving;

	assign tx_phase = phase == PH_STATUS ||
		(phase == PH_PAYLOAD && cmd == CMD_ARRAY_FETCH); // RULE15
	assign tx_load = tx_fire && tx_phase && tx_cnt == 3'h0;
	assign fifo_pop = tx_load && phase == PH_PAYLOAD && fifo_out_valid;
	assign tx_byte = (phase == PH_STATUS) ?
		status_image(busy, wel, block_guard, pin_guard) : // RULE5
		(fifo_out_valid ? fifo_out_data : 8'h00);

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_cnt <= 3'h0;
			tx_sh <= 8'h00;
			driving <= 1'b0;
			so_o <= 1'b0;
		end else if (cs_s) begin
			tx_cnt <= 3'h0;
			driving <= 1'b0;
		end else if (tx_fire && tx_phase) begin
			tx_cnt <= tx_cnt + 3'h1;
			driving <= 1'b1;
			if (tx_cnt == 3'h0) begin
				so_o <= tx_byte[7]; // RULE1
				tx_sh <= {tx_byte[6:0], 1'b0};
			end else begin
				so_o <= tx_sh[7];
				tx_sh <= {tx_sh[6:0], 1'b0};
			end
		end
	end

	// Output enable floats on deselect, hold and idle phases
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) so_oe_o <= 1'b0;
		else so_oe_o <= driving && !cs_s && !held && tx_phase; // RULE23 RULE24
	end
endmodule : spi_eeprom_command_protect

// file: spi_eeprom_command_protect_monitor.sv
// Port-level assertions for the serial EEPROM core
`timescale 1ns/10ps
module spi_eeprom_command_protect_monitor (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic hold_n_i,
	input wire logic wp_n_i,
	input wire logic so_o,
	input wire logic so_oe_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// Output stays floated on the first edge after reset
	property p_reset_quiet;
		!$past(resetn_i) |-> !so_oe_o;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("output enabled right after reset");
	// No drive in the first eight clocks after select falls
	property p_quiet_opcode;
		$fell(cs_n_i) |-> !so_oe_o [*8];
	endproperty
	a_quiet_opcode: assert property (p_quiet_opcode)
		else $error("output enabled during opcode");
	// Enable rises only inside a frame
	property p_oe_in_frame;
		$rose(so_oe_o) |-> !cs_n_i && !$past(cs_n_i, 4);
	endproperty
	a_oe_in_frame: assert property (p_oe_in_frame)
		else $error("output enabled outside a frame");
	// Enable rises after a falling sck
	property p_oe_after_fall;
		$rose(so_oe_o) |-> !$past(sck_i, 4);
	endproperty
	a_oe_after_fall: assert property (p_oe_after_fall)
		else $error("output enabled while sck high");
	// Driven data moves only after a falling sck
	property p_so_moves_low;
		so_oe_o && !cs_n_i && $changed(so_o) |-> !$past(sck_i, 3);
	endproperty
	a_so_moves_low: assert property (p_so_moves_low)
		else $error("data out changed off the falling edge");
	// Deselect floats the output within eight clocks
	property p_oe_drop;
		$rose(cs_n_i) |-> ##[1:8] !so_oe_o;
	endproperty
	a_oe_drop: assert property (p_oe_drop)
		else $error("output still driven after deselect");
	// Paused transfer keeps the output floated
	property p_hold_float;
		(!hold_n_i && !sck_i && !cs_n_i) [*8] |-> !so_oe_o;
	endproperty
	a_hold_float: assert property (p_hold_float)
		else $error("output driven while paused");
	// A stream ends only by deselect or pause
	property p_stream_end;
		$fell(so_oe_o) |-> cs_n_i || !hold_n_i;
	endproperty
	a_stream_end: assert property (p_stream_end)
		else $error("output stream stopped inside a frame");
endmodule : spi_eeprom_command_protect_monitor

bind spi_eeprom_command_protect spi_eeprom_command_protect_monitor
	spi_eeprom_command_protect_monitor_inst (.clock_i(clock_i),
	.resetn_i(resetn_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i),
	.hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o));

// file: spi_master_model.sv
// Mode 0 SPI master model that drives the device pins
`timescale 1ns/10ps
module spi_master_model (
	input wire logic clock_i,
	input wire logic so_i,
	input wire logic so_oe_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic si_o,
	output logic hold_n_o
);
	int lo_clk = 6; // Low half in clocks; raised for a slow master
	int hold_clk = 0; // Pause before each bit, sck low
	// Idle pins; sck rests low
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
		hold_n_o = 1'b1;
	end
	// Data line keeps toggling while not selected
	always @(negedge clock_i) begin
		if (cs_n_o) begin
			si_o <= ~si_o;
		end
	end
	// Select, then setup time before the first rise
	task automatic sel();
		@(negedge clock_i);
		cs_n_o = 1'b0;
		repeat (6) @(negedge clock_i);
	endtask : sel
	// One byte MSB first; data out taken at the end of each low half
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
		output logic [7:0] oe);
		for (int i = 7; i >= 0; i--) begin
			if (hold_clk > 0) begin
				hold_n_o = 1'b0;
				repeat (hold_clk) begin
					@(negedge clock_i);
					si_o = ~si_o;
				end
				hold_n_o = 1'b1;
			end
			si_o = tx[i];
			repeat (lo_clk) @(negedge clock_i);
			rx[i] = so_oe_i ? so_i : ~so_i; // Floated line reads inverted
			oe[i] = so_oe_i;
			sck_o = 1'b1;
			repeat (6) @(negedge clock_i);
			sck_o = 1'b0;
		end
	endtask : xfer
	// Deselect in the low half after the last bit, then rest
	task automatic desel();
		repeat (3) @(negedge clock_i);
		cs_n_o = 1'b1;
		repeat (24) @(negedge clock_i);
	endtask : desel
endmodule : spi_master_model

// file: spi_eeprom_command_protect_tb.sv
// Self-checking bench for the serial EEPROM command and protection core
`timescale 1ns/10ps
module spi_eeprom_command_protect_tb;
	import eeprom_pkg::*;
	localparam int AW = 14;
	localparam int WC = 600;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic wp_n_i = 1'b1;
	logic cs_n, sck, si, hold_n, so, so_oe;
	int miscompares = 0;
	int n_compared = 0;
	int t_busy = 0;
	logic [7:0] mem [int];
	bit latch, busy, pin_guard_enable, wp_cut;
	bit [1:0] bp;
	logic [7:0] q[$];
	logic [1:0] lv [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
	int pg [3] = '{16'h3000, 16'h2000, 16'h0040};
	logic [7:0] ops [4] = '{8'h06, 8'h04, 8'h0E, 8'h0C};
	// Core clock
	always #2 clock_i = ~clock_i;
	spi_eeprom_command_protect #(.ADDR_W(AW), .WRITE_CYCLES(WC))
		spi_eeprom_command_protect_inst (.clock_i(clock_i),
		.resetn_i(resetn_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
		.hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe));
	spi_master_model spi_master_model_inst (.clock_i(clock_i), .so_i(so),
		.so_oe_i(so_oe), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
		.hold_n_o(hold_n));
	// Comparisons and verdict
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: data %h expected %h", $time, got, exp);
		end
	endtask : cmp_byte
	task automatic cmp_oe(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: enable %h expected %h", $time, got, exp);
		end
	endtask : cmp_oe
	task automatic test_done();
		if (miscompares == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	// Reference status image and guarded ranges
	function automatic logic [7:0] status_img();
		if (busy) return STATUS_BUSY_IMAGE;
		return {pin_guard_enable, 3'b000, bp, latch, 1'b0};
	endfunction : status_img
	function automatic bit guarded(int a);
		int lim;
		lim = (bp == 2'h1) ? 16'h3000 : (bp == 2'h2) ? 16'h2000 : 0;
		return bp != 2'h0 && a >= lim;
	endfunction : guarded
	// One frame through the master, checked against the reference
	task automatic run(input logic [7:0] tx[$]);
		logic [7:0] rx, oe, op;
		int a, el;
		bit act;
		op = tx[0] & OPCODE_CARE_MASK;
		act = !busy || op == OP_STATUS_FETCH;
		a = (tx.size() > 2) ? {tx[1], tx[2]} & (2 ** AW - 1) : 0;
		spi_master_model_inst.sel();
		foreach (tx[i]) begin
			spi_master_model_inst.xfer(tx[i], rx, oe);
			if (i == 0 || !act || (op != OP_STATUS_FETCH &&
				(op != OP_ARRAY_FETCH || i < 3))) begin
				cmp_oe(oe, 8'h00);
			end else if (op == OP_STATUS_FETCH) begin
				el = int'($time) - t_busy;
				// Busy may end after the cycle time, must end a byte later
				if (busy && (el > WC * CLOCK_PERIOD_NS + 400 ||
					(el > WC * CLOCK_PERIOD_NS &&
					rx !== STATUS_BUSY_IMAGE))) begin
					busy = 0;
					latch = 0;
				end
				cmp_oe(oe, 8'hFF);
				cmp_byte(rx, status_img());
			end else begin
				cmp_oe(oe, 8'hFF);
				if (mem.exists(a)) cmp_byte(rx, mem[a]);
				a = (a + 1) % (2 ** AW);
			end
		end
		spi_master_model_inst.desel();
		if (!act) return;
		if (op == OP_LATCH_SET) latch = 1;
		if (op == OP_LATCH_CLEAR) latch = 0;
		if (op == OP_ARRAY_STORE && latch && !guarded(a) && tx.size() > 3) begin
			for (int i = 3; i < tx.size(); i++)
				mem[(a & ~63) | ((a + i - 3) & 63)] = tx[i];
			busy = 1;
			t_busy = int'($time);
		end
		if (op == OP_STATUS_STORE && latch &&
			!(pin_guard_enable && (!wp_n_i || wp_cut))) begin
			pin_guard_enable = tx[1][7];
			bp = tx[1][3:2];
			busy = 1;
			t_busy = int'($time);
		end
	endtask : run
	// Status polling until the write cycle ends, bounded
	task automatic poll();
		for (int n = 0; n < 40; n++) begin
			q = {OP_STATUS_FETCH, 8'($urandom)};
			run(q);
			if (!busy) break;
		end
		if (busy) begin
			miscompares++;
			test_done();
		end
	endtask : poll
	task automatic send1(input logic [7:0] b);
		q = {b};
		run(q);
	endtask : send1
	task automatic store(input int adr, input int n);
		adr = adr | ($urandom & 32'h0000_C000);
		send1(OP_LATCH_SET);
		q = {OP_ARRAY_STORE, 8'(adr >> 8), 8'(adr)};
		repeat (n) q.push_back(8'($urandom));
		run(q);
		poll();
	endtask : store
	task automatic fetch(input int adr, input int n);
		q = {OP_ARRAY_FETCH, 8'(adr >> 8), 8'(adr)};
		repeat (n) q.push_back(8'($urandom));
		run(q);
	endtask : fetch
	task automatic set_status(input logic [7:0] v);
		send1(OP_LATCH_SET);
		q = {OP_STATUS_STORE, v};
		run(q);
		poll();
	endtask : set_status
	// Main sequence
	initial begin
		void'($urandom(3803));
		repeat (12) @(negedge clock_i);
		resetn_i = 1'b1;
		repeat (6) @(negedge clock_i);
		q = {OP_STATUS_FETCH | 8'h08, 8'h00, 8'h00};
		run(q);
		foreach (ops[k]) begin
			send1(ops[k]);
			q = {OP_STATUS_FETCH, 8'h00};
			run(q);
		end
		store(16'h3FC0, 70);
		store(16'h0000, PAGE_BYTES);
		fetch(16'h3FF8, 16);
		q = {OP_ARRAY_STORE, 8'h00, 8'h00, 8'h5A};
		run(q);
		send1(OP_LATCH_SET);
		send1(OP_LATCH_CLEAR);
		run(q);
		fetch(0, 2);
		send1(OP_LATCH_SET);
		q = {OP_ARRAY_STORE, 8'h00, 8'h10, 8'h33};
		run(q);
		fetch(0, 1);
		poll();
		foreach (lv[k]) begin
			set_status(8'({lv[k], 2'b00}));
			foreach (pg[j]) begin
				store(pg[j], 4);
				fetch(pg[j], 4);
			end
		end
		set_status(8'h80);
		wp_n_i = 1'b0;
		set_status(8'h00);
		store(16'h0080, 3);
		fetch(16'h0080, 3);
		wp_n_i = 1'b1;
		send1(OP_LATCH_SET);
		q = {OP_STATUS_STORE, 8'h00};
		fork
			run(q);
			begin
				repeat (40) @(negedge clock_i);
				wp_n_i = 1'b0;
				wp_cut = 1;
				repeat (40) @(negedge clock_i);
				wp_n_i = 1'b1;
			end
		join
		poll();
		wp_cut = 0;
		wp_n_i = 1'b1;
		set_status(8'h00);
		q = {8'h07, 8'h05, 8'h05};
		run(q);
		spi_master_model_inst.hold_clk = 12;
		q = {OP_STATUS_FETCH, 8'h00, 8'h00};
		run(q);
		spi_master_model_inst.hold_clk = 0;
		test_done();
	end
endmodule : spi_eeprom_command_protect_tb
